// ### txs_pkg.sv
// Constants and types for the table-write, test-skip and literal-xor execution slice
package txs_pkg;
    localparam int          PTR_W               = 21;
    localparam int          HOLD_BYTES          = 8;
    localparam int          HOLD_SEL_W          = 3;
    localparam logic [13:0] TABLE_WRITE_PATTERN = 14'h0003;
    localparam logic [6:0]  TEST_SKIP_PATTERN   = 7'h33;
    localparam logic [7:0]  XOR_LITERAL_PATTERN = 8'h0A;
    localparam logic [7:0]  INDEXED_MAX         = 8'h5F;
    localparam logic [7:0]  ACCESS_SPLIT        = 8'h60;
    localparam logic [3:0]  ACCESS_HI_BANK      = 4'hF;
    localparam int          STATUS_N_POS        = 4;
    localparam int          STATUS_Z_POS        = 2;
    localparam logic [7:0]  WREG_RESET          = 8'h00;
    localparam logic [7:0]  STATUS_RESET        = 8'h00;
    localparam logic [7:0]  HOLD_RESET          = 8'hFF;

    typedef enum logic [1:0] {
        TXS_PTR_KEEP,
        TXS_PTR_POST_INC,
        TXS_PTR_POST_DEC,
        TXS_PTR_PRE_INC
    } txs_ptr_mode_t;

    typedef enum logic [1:0] {
        TXS_IDLE,
        TXS_TBL_WRITE,
        TXS_SKIP_NOP,
        TXS_SKIP_NOP2
    } txs_state_t;
endpackage : txs_pkg

// ### txs_operand_addr.sv
// Operand address former for byte-oriented file access
`timescale 1ns/10ps
module txs_operand_addr (
    // Instruction fields
    input  wire logic [7:0]  file_addr,
    input  wire logic        access_sel,
    // Core state
    input  wire logic [3:0]  bank_select_register,
    input  wire logic        ext_set_en,
    input  wire logic [11:0] index_base,
    // Formed address
    output logic      [11:0] operand_addr,
    output logic             indexed
);
    import txs_pkg::*;

    always_comb begin
        indexed = 1'b0;
        if (access_sel) begin
            operand_addr = {bank_select_register, file_addr};
        end else if (ext_set_en && file_addr <= INDEXED_MAX) begin
            operand_addr = index_base + {4'h0, file_addr};
            indexed = 1'b1;
        end else if (file_addr < ACCESS_SPLIT) begin
            operand_addr = {4'h0, file_addr};
        end else begin
            operand_addr = {ACCESS_HI_BANK, file_addr};
        end
    end
endmodule : txs_operand_addr

// ### txs_exec.sv
// Execution slice for table write, test-and-skip-if-zero and literal xor
`timescale 1ns/10ps
module txs_exec (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Decoded instruction from the fetch pipeline
    input  wire logic                   instr_valid,
    input  wire logic [15:0]            instr_word,
    input  wire logic                   next_is_two_word,
    // Core state
    input  wire logic [3:0]             bank_select_register,
    input  wire logic                   ext_set_en,
    input  wire logic [11:0]            index_base,
    input  wire logic [7:0]             table_latch,
    input  wire logic [txs_pkg::PTR_W-1:0] table_pointer,
    // Register file read port (combinational data for the presented address)
    output logic      [11:0]            file_rd_addr,
    input  wire logic [7:0]             file_rd_data,
    // Results
    output logic      [7:0]             wreg,
    output logic      [7:0]             status,
    output logic      [txs_pkg::PTR_W-1:0] table_pointer_new,
    output logic                        table_pointer_we,
    output logic      [8*txs_pkg::HOLD_BYTES-1:0] holding,
    output logic                        hold_byte_hi,
    output logic                        flush_fetch,
    output logic                        busy,
    output logic                        indexed_access
);
    import txs_pkg::*;

    function automatic logic is_table_write(input logic [15:0] w);
        return w[15:2] == TABLE_WRITE_PATTERN;
    endfunction : is_table_write

    function automatic logic is_test_skip(input logic [15:0] w);
        return w[15:9] == TEST_SKIP_PATTERN;
    endfunction : is_test_skip

    function automatic logic is_xor_literal(input logic [15:0] w);
        return w[15:8] == XOR_LITERAL_PATTERN;
    endfunction : is_xor_literal

    txs_state_t          state_q, state_d;
    logic [7:0]          wreg_q, wreg_d;
    logic [7:0]          status_q, status_d;
    logic [PTR_W-1:0]    ptr_q, ptr_d;
    logic                ptr_we_q, ptr_we_d;
    logic [7:0]          hold_q [HOLD_BYTES];
    logic [7:0]          hold_d [HOLD_BYTES];
    logic                byte_hi_q, byte_hi_d;
    logic                flush_q, flush_d;
    logic                idx_q, idx_d;
    logic                busy_q, busy_d;
    logic [PTR_W-1:0]    wr_ptr_q, wr_ptr_d;
    txs_ptr_mode_t       mode_q, mode_d;
    logic [11:0]         op_addr;
    logic                op_indexed;
    logic [7:0]          xor_res;
    logic                run;

    txs_operand_addr u_addr (
        .file_addr            (instr_word[7:0]),
        .access_sel           (instr_word[8]),
        .bank_select_register (bank_select_register),
        .ext_set_en           (ext_set_en),
        .index_base           (index_base),
        .operand_addr         (op_addr),
        .indexed              (op_indexed)
    );

    assign file_rd_addr = op_addr;
    assign run          = instr_valid && (state_q == TXS_IDLE);
    assign xor_res      = wreg_q ^ instr_word[7:0];

    always_comb begin
        state_d   = state_q;
        wreg_d    = wreg_q;
        status_d  = status_q;
        ptr_d     = ptr_q;
        ptr_we_d  = 1'b0;
        byte_hi_d = byte_hi_q;
        flush_d   = 1'b0;
        idx_d     = idx_q;
        wr_ptr_d  = wr_ptr_q;
        mode_d    = mode_q;
        for (int i = 0; i < HOLD_BYTES; i++) begin
            hold_d[i] = hold_q[i];
        end
        unique case (state_q)
            TXS_IDLE: begin
                if (run && is_xor_literal(instr_word)) begin
                    wreg_d = xor_res;
                    status_d[STATUS_N_POS] = xor_res[7];
                    status_d[STATUS_Z_POS] = (xor_res == 8'h00);
                end else if (run && is_test_skip(instr_word)) begin
                    idx_d = op_indexed;
                    if (file_rd_data == 8'h00) begin
                        flush_d = 1'b1;
                        state_d = next_is_two_word ? TXS_SKIP_NOP2 : TXS_SKIP_NOP;
                    end
                end else if (run && is_table_write(instr_word)) begin
                    mode_d = txs_ptr_mode_t'(instr_word[1:0]);
                    wr_ptr_d = (instr_word[1:0] == TXS_PTR_PRE_INC) ?
                               table_pointer + 1'b1 : table_pointer;
                    state_d = TXS_TBL_WRITE;
                end
            end
            TXS_TBL_WRITE: begin
                hold_d[wr_ptr_q[HOLD_SEL_W-1:0]] = table_latch;
                byte_hi_d = wr_ptr_q[0];
                ptr_we_d  = 1'b1;
                unique case (mode_q)
                    TXS_PTR_KEEP:     ptr_d = wr_ptr_q;
                    TXS_PTR_POST_INC: ptr_d = wr_ptr_q + 1'b1;
                    TXS_PTR_POST_DEC: ptr_d = wr_ptr_q - 1'b1;
                    TXS_PTR_PRE_INC:  ptr_d = wr_ptr_q;
                endcase
                state_d = TXS_IDLE;
            end
            TXS_SKIP_NOP2: begin
                state_d = TXS_SKIP_NOP;
            end
            TXS_SKIP_NOP: begin
                state_d = TXS_IDLE;
            end
        endcase
        // Busy is registered so the output comes straight from a flop
        busy_d = (state_d != TXS_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= TXS_IDLE;
            wreg_q    <= WREG_RESET;
            status_q  <= STATUS_RESET;
            ptr_q     <= '0;
            ptr_we_q  <= 1'b0;
            byte_hi_q <= 1'b0;
            flush_q   <= 1'b0;
            idx_q     <= 1'b0;
            busy_q    <= 1'b0;
            wr_ptr_q  <= '0;
            mode_q    <= TXS_PTR_KEEP;
            for (int i = 0; i < HOLD_BYTES; i++) begin
                hold_q[i] <= HOLD_RESET;
            end
        end else begin
            state_q   <= state_d;
            wreg_q    <= wreg_d;
            status_q  <= status_d;
            ptr_q     <= ptr_d;
            ptr_we_q  <= ptr_we_d;
            byte_hi_q <= byte_hi_d;
            flush_q   <= flush_d;
            idx_q     <= idx_d;
            busy_q    <= busy_d;
            wr_ptr_q  <= wr_ptr_d;
            mode_q    <= mode_d;
            for (int i = 0; i < HOLD_BYTES; i++) begin
                hold_q[i] <= hold_d[i];
            end
        end
    end

    generate
        for (genvar g = 0; g < HOLD_BYTES; g++) begin : g_hold
            assign holding[8*g +: 8] = hold_q[g];
        end
    endgenerate

    assign wreg              = wreg_q;
    assign status            = status_q;
    assign table_pointer_new = ptr_q;
    assign table_pointer_we  = ptr_we_q;
    assign hold_byte_hi      = byte_hi_q;
    assign flush_fetch       = flush_q;
    assign busy              = busy_q;
    assign indexed_access    = idx_q;
endmodule : txs_exec

// ### txs_exec_monitor.sv
// Checker for the execution slice
`timescale 1ns/10ps
module txs_exec_monitor (
    // Clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // Instruction and core state
    input wire logic             instr_valid,
    input wire logic [15:0]      instr_word,
    input wire logic             next_is_two_word,
    input wire logic [3:0]       bank_select_register,
    input wire logic             ext_set_en,
    input wire logic [11:0]      index_base,
    input wire logic [txs_pkg::PTR_W-1:0] table_pointer,
    input wire logic [11:0]      file_rd_addr,
    input wire logic [7:0]       file_rd_data,
    // Results
    input wire logic [7:0]       wreg,
    input wire logic [7:0]       status,
    input wire logic             table_pointer_we,
    input wire logic             hold_byte_hi,
    input wire logic             flush_fetch,
    input wire logic             busy
);
    import txs_pkg::*;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire       go = instr_valid && !busy;
    wire       xr = go && instr_word[15:8] == XOR_LITERAL_PATTERN;
    wire       ts = go && instr_word[15:9] == TEST_SKIP_PATTERN;
    wire       tw = go && instr_word[15:2] == TABLE_WRITE_PATTERN;
    wire       fz = ts && file_rd_data == 8'h00;
    wire [7:0] f  = instr_word[7:0];
    wire       hi = table_pointer[0] ^ (instr_word[1:0] == 2'h3);
    property p_xor; xr |=> wreg == ($past(wreg) ^ $past(f)); endproperty
    a_xor: assert property (p_xor) else $error("xor result wrong");
    property p_flg;
        xr |=> status[4] == wreg[7] && status[2] == (wreg == 8'h00)
            && (status & 8'hEB) == ($past(status) & 8'hEB);
    endproperty
    a_flg: assert property (p_flg) else $error("xor flags wrong");
    property p_sk1; fz && !next_is_two_word |=> flush_fetch && busy ##1 !busy; endproperty
    a_sk1: assert property (p_sk1) else $error("skip not taken");
    property p_sk2; fz && next_is_two_word |=> busy ##1 busy ##1 !busy; endproperty
    a_sk2: assert property (p_sk2) else $error("two word skip length");
    property p_nsk; ts && !fz |=> !flush_fetch && !busy; endproperty
    a_nsk: assert property (p_nsk) else $error("skip on nonzero");
    property p_sst; ts |=> $stable(status) && $stable(wreg); endproperty
    a_sst: assert property (p_sst) else $error("skip changed flags");
    property p_bnk; ts && instr_word[8] |-> file_rd_addr == {bank_select_register, f}; endproperty
    a_bnk: assert property (p_bnk) else $error("banked address wrong");
    property p_acc;
        ts && !instr_word[8] && !(ext_set_en && f <= INDEXED_MAX)
            |-> file_rd_addr == {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : 4'h0, f};
    endproperty
    a_acc: assert property (p_acc) else $error("fast bank address wrong");
    property p_idx;
        ts && !instr_word[8] && ext_set_en && f <= INDEXED_MAX
            |-> file_rd_addr == index_base + 12'(f);
    endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    property p_tbl; tw |=> busy ##1 table_pointer_we && !busy; endproperty
    a_tbl: assert property (p_tbl) else $error("table write timing");
    property p_thi; tw |-> ##2 hold_byte_hi == $past(hi, 2); endproperty
    a_thi: assert property (p_thi) else $error("word byte select wrong");
    c_xor: cover property (xr);
    c_sk2: cover property (fz && next_is_two_word);
    c_tbl: cover property (tw);
endmodule : txs_exec_monitor
bind txs_exec txs_exec_monitor txs_exec_monitor_i (
    .clk                  (clk),
    .reset_n              (reset_n),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .next_is_two_word     (next_is_two_word),
    .bank_select_register (bank_select_register),
    .ext_set_en           (ext_set_en),
    .index_base           (index_base),
    .table_pointer        (table_pointer),
    .file_rd_addr         (file_rd_addr),
    .file_rd_data         (file_rd_data),
    .wreg                 (wreg),
    .status               (status),
    .table_pointer_we     (table_pointer_we),
    .hold_byte_hi         (hold_byte_hi),
    .flush_fetch          (flush_fetch),
    .busy                 (busy)
);

// ### txs_file_model.sv
// Register file model for the combinational read port
`timescale 1ns/10ps
module txs_file_model (
    // Read port
    input  wire logic [11:0] file_rd_addr,
    output logic      [7:0]  file_rd_data
);
    // Zero only where the bank and both address nibbles agree
    assign file_rd_data = file_rd_addr[7:0] ^ {2{file_rd_addr[11:8]}};
endmodule : txs_file_model

// ### txs_exec_tb.sv
// Testbench for the execution slice
`timescale 1ns/10ps
module txs_exec_tb;
    import txs_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, iv = 1'b0, two = 1'b0, ext = 1'b0;
    logic [15:0]      iw = 16'h0000;
    logic [3:0]       bank_sel = 4'h0;
    logic [11:0]      base = 12'h1C3, ra;
    logic [7:0]       latch = 8'h34, rd, wreg, status;
    logic [PTR_W-1:0] ptr = 21'h01389A, pn;
    logic [63:0]      hold, eh;
    logic             we, hi, flush, busy, idx;
    int               error_cnt = 0, tests_run = 0;
    always #10 clk = ~clk;
    txs_exec txs_exec_i (.clk(clk), .reset_n(reset_n), .instr_valid(iv), .instr_word(iw),
        .next_is_two_word(two), .bank_select_register(bank_sel), .ext_set_en(ext),
        .index_base(base), .table_latch(latch), .table_pointer(ptr), .file_rd_addr(ra),
        .file_rd_data(rd), .wreg(wreg), .status(status), .table_pointer_new(pn),
        .table_pointer_we(we), .holding(hold), .hold_byte_hi(hi), .flush_fetch(flush),
        .busy(busy), .indexed_access(idx));
    txs_file_model txs_file_model_i (.file_rd_addr(ra), .file_rd_data(rd));
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic step;
        @(posedge clk);
        @(negedge clk);
    endtask : step
    task automatic issue(input logic [15:0] w);
        iw = w;
        iv = 1'b1;
        step();
    endtask : issue
    task automatic t_xor;
        issue(16'h0AAF);
        cmp(wreg, 8'hAF);
        cmp(status, 8'h10);
        issue(16'h0AAF);
        iv = 1'b0;
        cmp(wreg, 8'h00);
        cmp(status, 8'h04);
        $display("test xor done");
    endtask : t_xor
    task automatic t_tbl;
        logic [PTR_W-1:0] tgt;
        logic [PTR_W-1:0] nxt;
        eh = {8{HOLD_RESET}};
        for (int m = 0; m < 4; m++) begin
            tgt = (m == 3) ? ptr + 21'h1 : ptr;
            nxt = (m == 0) ? ptr : (m == 2) ? ptr - 21'h1 : ptr + 21'h1;
            eh[8*tgt[2:0] +: 8] = latch;
            issue({TABLE_WRITE_PATTERN, 2'(m)});
            // Held xor must be ignored while busy
            iw = 16'h0AFF;
            step();
            iv = 1'b0;
            cmp(hold, eh);
            cmp(pn, nxt);
            cmp(we, 1'b1);
            cmp(hi, tgt[0]);
            cmp(wreg, 8'h00);
            step();
            cmp(we, 1'b0);
            ptr = nxt;
            latch = latch + 8'h11;
        end
        $display("test table write done");
    endtask : t_tbl
    task automatic t_skip(input logic a, input logic [7:0] f, input logic [3:0] b,
                          input logic x, input logic tw, input logic z, input logic ix);
        bank_sel = b;
        ext = x;
        two = tw;
        issue({TEST_SKIP_PATTERN, a, f});
        iv = 1'b0;
        cmp(flush, z);
        cmp(busy, z);
        cmp(idx, ix);
        cmp(status, 8'h04);
        step();
        cmp(busy, z & tw);
        cmp(flush, 1'b0);
        step();
        cmp(busy, 1'b0);
        $display("test skip f=%h done", f);
    endtask : t_skip
    task automatic report_and_stop;
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        cmp(hold, {8{HOLD_RESET}});
        cmp(wreg, WREG_RESET);
        t_xor();
        t_tbl();
        t_skip(1'b1, 8'h33, 4'h3, 1'b0, 1'b0, 1'b1, 1'b0);
        t_skip(1'b1, 8'h33, 4'h4, 1'b0, 1'b1, 1'b0, 1'b0);
        t_skip(1'b0, 8'hFF, 4'h3, 1'b0, 1'b1, 1'b1, 1'b0);
        t_skip(1'b0, 8'h22, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0);
        t_skip(1'b0, 8'h5F, 4'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        t_skip(1'b0, 8'h60, 4'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : txs_exec_tb
